// >>> rtl/tpw_top.sv
// Top of the 8-bit timer waveform unit: AHB-Lite register slave,
// counter with fast and dual-slope PWM, two compare outputs, pins.
// Assumes a single master, word transfers, zero-wait slave timing.
`timescale 1ns/1ps
module tpw_top #(
   parameter int AW = 8
) (
   // Clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   // Waveform pins
   output logic             wave_pin_a_out,
   output logic             wave_pin_a_oe,
   output logic             wave_pin_b_out,
   output logic             wave_pin_b_oe
);
   // -----------------------------------------------------------------
   // Elaboration check
   // -----------------------------------------------------------------
   if (AW < 8 || AW > 32)
   begin : g_bad_aw
      $error("tpw_top: AW must lie between 8 and 32");
   end

   // -----------------------------------------------------------------
   // State
   // -----------------------------------------------------------------
   typedef struct packed {
      logic [7:0]    ctrl_a;
      logic [7:0]    ctrl_b;
      logic [7:0]    cmp_a;
      logic [7:0]    cmp_b;
      logic [7:0]    cmp_a_buf;
      logic [7:0]    cmp_b_buf;
      logic [7:0]    count;
      logic [7:0]    port;
      logic          dir_up;
      logic          ovf;
      logic          mfa;
      logic          mfb;
      logic          wr_pend;
      logic [AW-1:0] wr_addr;
      logic [31:0]   rdata;
      logic          ready;
      logic          resp;
      logic          pin_a_out;
      logic          pin_a_oe;
      logic          pin_b_out;
      logic          pin_b_oe;
   } tpw_state_type;

   localparam tpw_state_type RST_STATE = '{ready: 1'b1, dir_up: 1'b1,
                                           default: '0};

   tpw_state_type q;
   tpw_state_type d;

   // -----------------------------------------------------------------
   // Functions
   // -----------------------------------------------------------------
   // Address compare against a byte offset
   function automatic logic hit(input logic [AW-1:0] a,
                                input logic [7:0]    ofs);
      hit = (a == AW'(ofs));
   endfunction

   // Register read view of a state
   function automatic logic [31:0] rd_word(input tpw_state_type s,
                                           input logic [AW-1:0] a);
      logic [7:0] v;
      v = 8'h00;
      if (hit(a, tpw_pkg::CTRL_A_OFS))
         v = s.ctrl_a & tpw_pkg::CTRL_A_WMASK;
      else if (hit(a, tpw_pkg::CTRL_B_OFS))
         v = s.ctrl_b & tpw_pkg::CTRL_B_WMASK;
      else if (hit(a, tpw_pkg::CMP_A_OFS))
         v = s.cmp_a;
      else if (hit(a, tpw_pkg::CMP_B_OFS))
         v = s.cmp_b;
      else if (hit(a, tpw_pkg::COUNT_OFS))
         v = s.count;
      else if (hit(a, tpw_pkg::STATUS_OFS))
         v = {5'h00, s.mfb, s.mfa, s.ovf};
      else if (hit(a, tpw_pkg::PORT_OFS))
         v = s.port & tpw_pkg::PORT_WMASK;
      rd_word = {24'h000000, v};
   endfunction

   // Next direction and count on a tick: {dir_up, count}
   function automatic logic [8:0] step(input logic [7:0] c,
                                       input logic       up,
                                       input logic [7:0] top,
                                       input logic       fast,
                                       input logic       dual,
                                       input logic       ctc,
                                       input logic [7:0] cmp);
      logic [7:0] one;
      one = (top == tpw_pkg::CNT_BOTTOM) ? 8'h00 : 8'h01;
      if (dual && up && c >= top)
         step = {1'b0, c - one};
      else if (dual && up)
         step = {1'b1, c + 8'h01};
      else if (dual && c == tpw_pkg::CNT_BOTTOM)
         step = {1'b1, one};
      else if (dual)
         step = {1'b0, c - 8'h01};
      else if (fast && c == top)
         step = {1'b1, tpw_pkg::CNT_BOTTOM};
      else if (ctc && c == cmp)
         step = {1'b1, tpw_pkg::CNT_BOTTOM};
      else
         step = {1'b1, c + 8'h01};
   endfunction

   // -----------------------------------------------------------------
   // Mode decode and counter events
   // -----------------------------------------------------------------
   logic [2:0] wave_mode;
   logic       wave_mode_hi;
   logic       pwm_fast;
   logic       pwm_dual;
   logic       ctc_mode;
   logic       timer_tick;
   logic [7:0] top_val;
   logic       at_top;
   logic       at_bottom;
   logic [8:0] next_step;
   logic       match_up;
   logic       match_a;
   logic       match_b;
   logic       fast_wrap;
   logic       dual_top;
   logic       dual_bot;
   logic       update_pt;
   logic       ovf_set;
   logic       oc_a;
   logic       oc_b;
   logic       conn_a;
   logic       conn_b;

   // Wave mode assembled from both control registers
   assign wave_mode_hi = q.ctrl_b[tpw_pkg::WMH_BIT];
   assign wave_mode    = {wave_mode_hi,
                          q.ctrl_a[tpw_pkg::WML_LSB+1:tpw_pkg::WML_LSB]};
   assign pwm_fast = (wave_mode == tpw_pkg::WM_FAST_FF) ||
                     (wave_mode == tpw_pkg::WM_FAST_CMP);
   assign pwm_dual = (wave_mode == tpw_pkg::WM_DUAL_FF) ||
                     (wave_mode == tpw_pkg::WM_DUAL_CMP);
   assign ctc_mode = (wave_mode == tpw_pkg::WM_CTC);

   // Top is the buffered channel A compare in modes 5 and 7
   assign top_val = (wave_mode == tpw_pkg::WM_DUAL_CMP ||
                     wave_mode == tpw_pkg::WM_FAST_CMP) ?
                    q.cmp_a_buf : tpw_pkg::CNT_MAX;
   assign at_top    = (q.count == top_val);
   assign at_bottom = (q.count == tpw_pkg::CNT_BOTTOM);
   assign next_step = step(q.count, q.dir_up, top_val, pwm_fast,
                           pwm_dual, ctc_mode, q.cmp_a);

   // Matches count as up-slope at bottom, down-slope at top
   assign match_up  = at_bottom | (q.dir_up & ~at_top);
   assign match_a   = timer_tick & (q.count == q.cmp_a_buf);
   assign match_b   = timer_tick & (q.count == q.cmp_b_buf);
   assign fast_wrap = timer_tick & pwm_fast & at_top;
   assign dual_top  = timer_tick & pwm_dual & q.dir_up & at_top;
   assign dual_bot  = timer_tick & pwm_dual & ~q.dir_up &
                      (next_step[7:0] == tpw_pkg::CNT_BOTTOM);
   assign update_pt = fast_wrap | dual_top;

   // Overflow: fast on reaching top, dual at bottom, else on wrap from MAX
   assign ovf_set = pwm_fast ?
                    timer_tick & (next_step[7:0] == top_val) :
                    pwm_dual ? dual_bot :
                    timer_tick & (q.count == tpw_pkg::CNT_MAX) &
                    (next_step[7:0] == tpw_pkg::CNT_BOTTOM);

   // -----------------------------------------------------------------
   // Sub-blocks
   // -----------------------------------------------------------------
   // Prescaler supplying the tick enable
   tpw_prescaler u_pre (
      .hclk       (hclk),
      .hresetn    (hresetn),
      .clk_select (q.ctrl_b[tpw_pkg::CS_LSB+2:tpw_pkg::CS_LSB]),
      .timer_tick (timer_tick)
   );

   // Channel A compare output, with toggle option
   tpw_channel #(
      .HAS_TOGGLE (1'b1)
   ) u_ch_a (
      .hclk         (hclk),
      .hresetn      (hresetn),
      .pwm_fast     (pwm_fast),
      .pwm_dual     (pwm_dual),
      .wave_mode_hi (wave_mode_hi),
      .out_mode_n   (q.ctrl_a[tpw_pkg::OMA_LSB+1:tpw_pkg::OMA_LSB]),
      .match        (match_a),
      .match_up     (match_up),
      .wrap_evt     (fast_wrap),
      .top_evt      (dual_top),
      .bottom_evt   (dual_bot),
      .cmp_is_top   (q.cmp_a_buf == top_val),
      .wave_out_n   (oc_a),
      .connected    (conn_a)
   );

   // Channel B compare output, no toggle in PWM
   tpw_channel #(
      .HAS_TOGGLE (1'b0)
   ) u_ch_b (
      .hclk         (hclk),
      .hresetn      (hresetn),
      .pwm_fast     (pwm_fast),
      .pwm_dual     (pwm_dual),
      .wave_mode_hi (wave_mode_hi),
      .out_mode_n   (q.ctrl_a[tpw_pkg::OMB_LSB+1:tpw_pkg::OMB_LSB]),
      .match        (match_b),
      .match_up     (match_up),
      .wrap_evt     (fast_wrap),
      .top_evt      (dual_top),
      .bottom_evt   (dual_bot),
      .cmp_is_top   (q.cmp_b_buf == top_val),
      .wave_out_n   (oc_b),
      .connected    (conn_b)
   );

   // -----------------------------------------------------------------
   // Next state
   // -----------------------------------------------------------------
   logic          req;
   logic          wr;
   logic [AW-1:0] wa;
   logic [7:0]    wb;

   assign req = hsel & htrans[1] & hready;
   assign wr  = q.wr_pend;
   assign wa  = q.wr_addr;
   assign wb  = hwdata[7:0];

   // One process fills the whole next state
   always_comb
   begin
      d = q;
      // Counter advances only on ticks
      if (timer_tick)
      begin
         d.dir_up = next_step[8];
         d.count  = next_step[7:0];
      end
      // Compare buffers: immediate outside PWM, else at update point
      if (!(pwm_fast || pwm_dual) || update_pt)
      begin
         d.cmp_a_buf = q.cmp_a;
         d.cmp_b_buf = q.cmp_b;
      end
      // Address phase capture
      d.wr_pend = req & hwrite;
      d.wr_addr = haddr[AW-1:0];
      // Data phase writes
      if (wr && hit(wa, tpw_pkg::CTRL_A_OFS))
         d.ctrl_a = wb & tpw_pkg::CTRL_A_WMASK;
      else if (wr && hit(wa, tpw_pkg::CTRL_B_OFS))
         d.ctrl_b = wb & tpw_pkg::CTRL_B_WMASK;
      else if (wr && hit(wa, tpw_pkg::CMP_A_OFS))
         d.cmp_a = wb;
      else if (wr && hit(wa, tpw_pkg::CMP_B_OFS))
         d.cmp_b = wb;
      else if (wr && hit(wa, tpw_pkg::COUNT_OFS))
         d.count = wb;
      else if (wr && hit(wa, tpw_pkg::PORT_OFS))
         d.port = wb & tpw_pkg::PORT_WMASK;
      // Sticky flags: write one clears, a new event wins
      if (wr && hit(wa, tpw_pkg::STATUS_OFS))
      begin
         d.ovf = q.ovf & ~wb[tpw_pkg::FLAG_OVF];
         d.mfa = q.mfa & ~wb[tpw_pkg::FLAG_MA];
         d.mfb = q.mfb & ~wb[tpw_pkg::FLAG_MB];
      end
      if (ovf_set) d.ovf = 1'b1;
      if (match_a) d.mfa = 1'b1;
      if (match_b) d.mfb = 1'b1;
      // Pins: compare output overrides port data; direction enables
      d.pin_a_out = conn_a ? oc_a : q.port[tpw_pkg::DAT_A];
      d.pin_b_out = conn_b ? oc_b : q.port[tpw_pkg::DAT_B];
      d.pin_a_oe  = q.port[tpw_pkg::DIR_A];
      d.pin_b_oe  = q.port[tpw_pkg::DIR_B];
      // Read data from the next state so writes are seen at once
      d.ready = 1'b1;
      d.resp  = 1'b0;
      d.rdata = (req && !hwrite) ? rd_word(d, haddr[AW-1:0]) : 32'h0;
   end

   // -----------------------------------------------------------------
   // State register and outputs
   // -----------------------------------------------------------------
   // State register
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn) q <= RST_STATE;
      else q <= d;
   end

   // Outputs straight from flip-flops
   assign hreadyout      = q.ready;
   assign hresp          = q.resp;
   assign hrdata         = q.rdata;
   assign wave_pin_a_out = q.pin_a_out;
   assign wave_pin_a_oe  = q.pin_a_oe;
   assign wave_pin_b_out = q.pin_b_out;
   assign wave_pin_b_oe  = q.pin_b_oe;

endmodule

// >>> inc/tpw_pkg.sv
// Shared constants of the 8-bit timer waveform unit: register map,
// field positions, reset values, mode and prescale encodings.
// Assumes one clock and word-aligned AHB-Lite register access.
// Notes on behaviour
// - Fast PWM sets overflow flag reaching top
// - Fast PWM: mode two normal, three inverted
// - PWM: mode one toggles A only with wave_mode_hi
// - Fast PWM: change at match, opposite at wrap
// - Fast PWM: bottom spike, MAX constant level
// - Fast PWM toggle gives square wave, buffered
// - Modes 1, 5 count dual-slope; top FF/compare
// - Dual PWM: mode two clears up, sets down
// - Dual PWM holds top one tick, reverses
// - Dual PWM sets overflow flag at bottom only
// - Dual PWM: bottom low, MAX high, inverted opposite
// - Dual PWM: forced edge when up match missed
// - Dual PWM: level at MAX is fixed
// - Counter advances only on timer tick enable
// - Periods N*256 fast, N*510 dual, with top at MAX
// - Nonzero mode overrides pin, except toggle in PWM without toggle support; direction gates drive
// - Non-PWM: off, toggle, clear, set on match
// - Fast PWM: clear/set on match, opposite bottom
// - Fast PWM compare at top: act at bottom
// - Dual PWM compare at top: act at top
// - Control A layout, bits 3:2 zero, reset 0
// - Wave mode high bit in control B
// - Fast PWM counts to top, then zero
// - Reset clears compare output state
package tpw_pkg;
   // Register byte offsets
   localparam logic [7:0] CTRL_A_OFS = 8'h24;
   localparam logic [7:0] CTRL_B_OFS = 8'h28;
   localparam logic [7:0] CMP_A_OFS  = 8'h2c;
   localparam logic [7:0] CMP_B_OFS  = 8'h30;
   localparam logic [7:0] COUNT_OFS  = 8'h34;
   localparam logic [7:0] STATUS_OFS = 8'h38;
   localparam logic [7:0] PORT_OFS   = 8'h3c;
   // Field positions
   localparam int OMA_LSB  = 6;
   localparam int OMB_LSB  = 4;
   localparam int WML_LSB  = 0;
   localparam int WMH_BIT  = 3;
   localparam int CS_LSB   = 0;
   localparam int FLAG_OVF = 0;
   localparam int FLAG_MA  = 1;
   localparam int FLAG_MB  = 2;
   localparam int DIR_A    = 0;
   localparam int DIR_B    = 1;
   localparam int DAT_A    = 2;
   localparam int DAT_B    = 3;
   // Reset values and writable masks
   localparam logic [7:0] REG_RST      = 8'h00;
   localparam logic [7:0] CTRL_A_WMASK = 8'hf3;
   localparam logic [7:0] CTRL_B_WMASK = 8'h0f;
   localparam logic [7:0] PORT_WMASK   = 8'h0f;
   localparam logic [7:0] CNT_BOTTOM   = 8'h00;
   localparam logic [7:0] CNT_MAX      = 8'hff;
   // Wave modes
   localparam logic [2:0] WM_NORMAL   = 3'h0;
   localparam logic [2:0] WM_DUAL_FF  = 3'h1;
   localparam logic [2:0] WM_CTC      = 3'h2;
   localparam logic [2:0] WM_FAST_FF  = 3'h3;
   localparam logic [2:0] WM_DUAL_CMP = 3'h5;
   localparam logic [2:0] WM_FAST_CMP = 3'h7;
   // Output modes
   localparam logic [1:0] OM_OFF    = 2'h0;
   localparam logic [1:0] OM_TOGGLE = 2'h1;
   // Clock select and prescale masks (N = 1, 8, 64, 256, 1024)
   localparam logic [2:0] CS_DIV1    = 3'h1;
   localparam logic [2:0] CS_DIV8    = 3'h2;
   localparam logic [2:0] CS_DIV64   = 3'h3;
   localparam logic [2:0] CS_DIV256  = 3'h4;
   localparam logic [2:0] CS_DIV1024 = 3'h5;
   localparam logic [9:0] PRE_MASK_8    = 10'h007;
   localparam logic [9:0] PRE_MASK_64   = 10'h03f;
   localparam logic [9:0] PRE_MASK_256  = 10'h0ff;
   localparam logic [9:0] PRE_MASK_1024 = 10'h3ff;
endpackage

// >>> rtl/tpw_prescaler.sv
// Prescaler producing the one-cycle timer tick enable.
// Assumes hclk is the I/O clock; select codes outside 1..5 stop it.
`timescale 1ns/1ps
module tpw_prescaler (
   // Clock and reset
   input  wire logic       hclk,
   input  wire logic       hresetn,
   // Clock select
   input  wire logic [2:0] clk_select,
   // Tick enable
   output logic            timer_tick
);
   typedef struct packed {
      logic [9:0] div;
   } tpw_pre_state_type;

   tpw_pre_state_type q;
   tpw_pre_state_type d;

   // Tick when the divider low bits wrap for the chosen factor
   function automatic logic tick_of(input logic [2:0] cs,
                                    input logic [9:0] dv);
      logic [9:0] m;
      m = tpw_pkg::PRE_MASK_1024;
      if (cs == tpw_pkg::CS_DIV8) m = tpw_pkg::PRE_MASK_8;
      else if (cs == tpw_pkg::CS_DIV64) m = tpw_pkg::PRE_MASK_64;
      else if (cs == tpw_pkg::CS_DIV256) m = tpw_pkg::PRE_MASK_256;
      if (cs == tpw_pkg::CS_DIV1) tick_of = 1'b1;
      else if (cs >= tpw_pkg::CS_DIV8 && cs <= tpw_pkg::CS_DIV1024)
         tick_of = ((dv & m) == m);
      else tick_of = 1'b0;
   endfunction

   // Divider runs whenever the clock select is nonzero
   always_comb
   begin
      d     = q;
      d.div = (clk_select == 3'h0) ? 10'h000 : q.div + 10'h001;
   end

   assign timer_tick = tick_of(clk_select, q.div);

   // State register
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn) q <= '0;
      else q <= d;
   end
endmodule

// >>> rtl/tpw_channel.sv
// One compare output unit: holds the internal compare output bit.
// Assumes tick-qualified match and slope events from the counter.
`timescale 1ns/1ps
module tpw_channel #(
   parameter bit HAS_TOGGLE = 1'b1
) (
   // Clock and reset
   input  wire logic       hclk,
   input  wire logic       hresetn,
   // Mode
   input  wire logic       pwm_fast,
   input  wire logic       pwm_dual,
   input  wire logic       wave_mode_hi,
   input  wire logic [1:0] out_mode_n,
   // Counter events
   input  wire logic       match,
   input  wire logic       match_up,
   input  wire logic       wrap_evt,
   input  wire logic       top_evt,
   input  wire logic       bottom_evt,
   input  wire logic       cmp_is_top,
   // Result
   output logic            wave_out_n,
   output logic            connected
);
   typedef struct packed {
      logic oc;
      logic up_seen;
   } tpw_ch_state_type;

   tpw_ch_state_type q;
   tpw_ch_state_type d;
   logic pwm;
   logic tog_ok;

   // Toggle in PWM exists only on channel A with wave_mode_hi
   assign pwm    = pwm_fast | pwm_dual;
   assign tog_ok = HAS_TOGGLE & wave_mode_hi;
   assign connected = (out_mode_n != tpw_pkg::OM_OFF) &&
                      !(pwm && out_mode_n == tpw_pkg::OM_TOGGLE
                        && !tog_ok);
   assign wave_out_n = q.oc;

   // Output compare actions per mode
   always_comb
   begin
      d = q;
      if (!pwm)
      begin
         if (match && out_mode_n == tpw_pkg::OM_TOGGLE) d.oc = ~q.oc;
         else if (match && out_mode_n[1]) d.oc = out_mode_n[0];
      end
      else if (out_mode_n == tpw_pkg::OM_TOGGLE)
      begin
         if (match && tog_ok) d.oc = ~q.oc;
      end
      else if (out_mode_n[1] && pwm_fast)
      begin
         if (match && !cmp_is_top) d.oc = out_mode_n[0];
         if (wrap_evt) d.oc = ~out_mode_n[0];
      end
      else if (out_mode_n[1])
      begin
         if (match && !cmp_is_top)
         begin
            d.oc = match_up ? out_mode_n[0] : ~out_mode_n[0];
            if (match_up) d.up_seen = 1'b1;
         end
         if (top_evt && cmp_is_top) d.oc = ~out_mode_n[0];
         else if (top_evt && !q.up_seen) d.oc = out_mode_n[0];
         if (bottom_evt) d.up_seen = 1'b0;
      end
   end

   // State register
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn) q <= '0;
      else q <= d;
   end
endmodule

// >>> dv/tpw_monitor.sv
// Checker for the waveform unit top: bus answers, pin reset and direction enables.
// Assumes it is bound to tpw_top and sees only that module's ports.
`timescale 1ns/1ps
module tpw_monitor #(
   parameter int AW = 8
) (
   // Clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // Register bus
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   input  wire logic        hreadyout,
   input  wire logic        hresp,
   input  wire logic [31:0] hrdata,
   // Waveform pins
   input  wire logic        wave_pin_a_out,
   input  wire logic        wave_pin_a_oe,
   input  wire logic        wave_pin_b_out,
   input  wire logic        wave_pin_b_oe
);
   logic       rd_ph_q;
   logic       wr_ph_q;
   logic [7:0] ofs_q;
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // Track which data phase is under way
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         rd_ph_q <= 1'b0;
         wr_ph_q <= 1'b0;
         ofs_q   <= 8'h00;
      end
      else
      begin
         rd_ph_q <= hsel && htrans[1] && hready && !hwrite;
         wr_ph_q <= hsel && htrans[1] && hready && hwrite;
         ofs_q   <= haddr[7:0];
      end
   end
   // Bus answers
   a_ready_always: assert property (hreadyout)
      else $error("slave inserted a wait state");
   a_resp_okay: assert property (!hresp)
      else $error("slave answered with an error");
   a_rdata_idle: assert property (!rd_ph_q |-> hrdata == 32'h0)
      else $error("read data outside a read data phase");
   a_rdata_upper: assert property (rd_ph_q |-> hrdata[31:8] == 24'h0)
      else $error("read data upper lanes not zero");
   a_ctrl_reserved: assert property
      (rd_ph_q && ofs_q == tpw_pkg::CTRL_A_OFS |-> hrdata[3:2] == 2'h0)
      else $error("reserved control bits read nonzero");
   // Pins after reset and under direction control
   a_pins_reset: assert property ($rose(hresetn) |->
      !wave_pin_a_out && !wave_pin_b_out && !wave_pin_a_oe)
      else $error("pins not quiet after reset");
   a_oe_dir_a: assert property (wr_ph_q && ofs_q == tpw_pkg::PORT_OFS
      && hwdata[tpw_pkg::DIR_A] |-> ##[1:3] wave_pin_a_oe)
      else $error("pin a not driven after direction set");
   a_oe_dir_b: assert property (wr_ph_q && ofs_q == tpw_pkg::PORT_OFS
      && hwdata[tpw_pkg::DIR_B] |-> ##[1:3] wave_pin_b_oe)
      else $error("pin b not driven after direction set");
endmodule
bind tpw_top tpw_monitor #(.AW(AW)) i_tpw_monitor (.hclk, .hresetn, .hsel,
   .haddr, .htrans, .hwrite, .hwdata, .hready, .hreadyout, .hresp, .hrdata,
   .wave_pin_a_out, .wave_pin_a_oe, .wave_pin_b_out, .wave_pin_b_oe);

// >>> dv/tpw_load.sv
// Load on the two waveform pins, each with a pull-up.
// Assumes pin levels and enables straight from the design.
`timescale 1ns/1ps
module tpw_load (
   // Pin drivers
   input  wire logic a_out,
   input  wire logic a_oe,
   input  wire logic b_out,
   input  wire logic b_oe,
   // Resolved pin levels
   output logic      lvl_a,
   output logic      lvl_b
);
   // Pull-up wins when the device does not drive
   assign lvl_a = a_oe ? a_out : 1'b1;
   assign lvl_b = b_oe ? b_out : 1'b1;
endmodule

// >>> dv/timer8_pwm_waveform_unit_test.sv
// Testbench: high-cycle count of both pins over one waveform period.
// Assumes tpw_top, tpw_load and the bound checker.
`timescale 1ns/1ps
module timer8_pwm_waveform_unit_test;
   logic        hclk = 1'b0;
   logic        hresetn = 1'b0;
   logic        hsel = 1'b0;
   logic        hwrite = 1'b0;
   logic [1:0]  htrans = 2'h0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata, rd;
   logic        hreadyout, hresp, pa, pae, pb, pbe, lvl_a, lvl_b;
   int          n_errors = 0;
   int          cmp_count = 0;
   int          cyc = 0;
   // Clock, 4 ns period
   always #2 hclk = ~hclk;
   tpw_top i_tpw_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
      .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .wave_pin_a_out(pa),
      .wave_pin_a_oe(pae), .wave_pin_b_out(pb), .wave_pin_b_oe(pbe));
   tpw_load i_tpw_load (.a_out(pa), .a_oe(pae), .b_out(pb), .b_oe(pbe),
      .lvl_a(lvl_a), .lvl_b(lvl_b));
   // Verdict, from the main sequence or the hang guard
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // Hang guard
   always @(posedge hclk)
   begin
      cyc++;
      if (cyc == 80000)
      begin
         n_errors++;
         summarize();
      end
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("unexpected at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // One single word transfer; read data lands in rd
   task automatic xfer(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h0, a};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask
   // High cycles of a pin over one window of w cycles
   function automatic int exp_hi(int wm, int om, int cmp, int pd, int w,
                                 bit is_a);
      if (om == 0 || (om == 1 && wm % 2 == 1 && !(is_a && wm > 3)))
         return pd * w;
      if (om == 1)
         return w / 2;
      if (wm == 0 || wm == 2)
         return (om == 3) ? w : 0;
      if (wm == 1 || wm == 5)
         return (om == 2) ? 2 * cmp : w - 2 * cmp;
      return (om == 2) ? cmp + 1 : w - cmp - 1;
   endfunction
   // Configure, settle, then count highs over one period
   task automatic run(input logic [2:0] wm, input logic [1:0] oma,
                      input logic [1:0] omb, input logic [7:0] ca,
                      input logic [7:0] cb, input logic pd);
      int w, ha, hb;
      w = (wm == 1) ? 510 : (wm == 5) ? 2 * ca :
          (wm == 7 || wm == 2) ? 2 * (ca + 1) : 256;
      xfer(1'b1, tpw_pkg::CTRL_B_OFS, {28'h0, wm[2], 3'h1});
      xfer(1'b1, tpw_pkg::CMP_A_OFS, {24'h0, ca});
      xfer(1'b1, tpw_pkg::CMP_B_OFS, {24'h0, cb});
      xfer(1'b1, tpw_pkg::PORT_OFS, {28'h0, pd, pd, 2'h3});
      xfer(1'b1, tpw_pkg::CTRL_A_OFS, {24'h0, oma, omb, 2'h0, wm[1:0]});
      repeat (2 * w + 600) @(posedge hclk);
      ha = 0;
      hb = 0;
      repeat (w)
      begin
         @(posedge hclk);
         ha += lvl_a;
         hb += lvl_b;
      end
      check(ha, exp_hi(wm, oma, ca, pd, w, 1));
      check(hb, exp_hi(wm, omb, cb, pd, w, 0));
      $display("test done: mode %0d out %0d %0d", wm, oma, omb);
   endtask
   initial
   begin
      logic [2:0] wm;
      void'($urandom(32'h46ce925f));
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      xfer(1'b0, tpw_pkg::CTRL_A_OFS, 32'h0);
      check(rd, 32'h0);
      xfer(1'b1, tpw_pkg::CTRL_A_OFS, 32'hff);
      xfer(1'b0, tpw_pkg::CTRL_A_OFS, 32'h0);
      check(rd, 32'hf3);
      xfer(1'b1, 8'h80, 32'hff);
      xfer(1'b0, 8'h80, 32'h0);
      check(rd, 32'h0);
      $display("test done: register access");
      run(3'h3, 2'h2, 2'h3, 8'h00, 8'hff, 1'b0);
      run(3'h3, 2'h3, 2'h2, 8'hff, 8'h00, 1'b0);
      run(3'h1, 2'h2, 2'h3, 8'h00, 8'hff, 1'b0);
      run(3'h1, 2'h3, 2'h2, 8'hff, 8'h80, 1'b0);
      run(3'h5, 2'h2, 2'h3, 8'h0a, 8'h04, 1'b0);
      run(3'h7, 2'h1, 2'h0, 8'h09, 8'h00, 1'b1);
      run(3'h3, 2'h1, 2'h1, 8'h28, 8'h28, 1'b1);
      run(3'h0, 2'h3, 2'h2, 8'h4d, 8'h4d, 1'b0);
      run(3'h2, 2'h1, 2'h1, 8'h07, 8'h03, 1'b0);
      run(3'h0, 2'h0, 2'h0, 8'h05, 8'h05, 1'b1);
      repeat (8)
      begin
         wm = ($urandom % 2) ? 3'h3 : 3'h1;
         run(wm, 2'h2 | 2'($urandom % 2), 2'h2 | 2'($urandom % 2),
             8'($urandom), 8'($urandom), 1'b0);
      end
      xfer(1'b1, tpw_pkg::STATUS_OFS, 32'h7);
      repeat (600) @(posedge hclk);
      xfer(1'b0, tpw_pkg::STATUS_OFS, 32'h0);
      check({31'h0, rd[0]}, 32'h1);
      $display("test done: overflow flag");
      summarize();
   end
endmodule
